//--- gfx_source.sv
module gfx_source (
	input  wire logic                   clk_i,
	output pixel_decoder_pkg::port_in_s port1_o,
	output pixel_decoder_pkg::port_in_s port2_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        dual     = 1'b0;
	logic        ycc      = 1'b0;
	logic [1:0]  clk_mask = 2'b11;
	logic        ck       = 1'b0;
	logic        hs       = 1'b0;
	logic        de       = 1'b0;
	logic [11:0] d1       = 12'h000;
	logic [11:0] d2       = 12'h000;

	// A port left out of clk_mask keeps its clock pair still, as an unused port would.
	assign port1_o = '{d1, hs, 1'b0, de, ck & clk_mask[0], ~(ck & clk_mask[0])};
	assign port2_o = '{d2, hs, 1'b0, de, ck & clk_mask[1], ~(ck & clk_mask[1])};

	task automatic word(input logic [11:0] a, input logic [11:0] b);
		@(posedge clk_i);
		d1 <= a;
		d2 <= b;
		de <= 1'b1;
		if (dual)
			ck <= ~ck;
		else
		begin
			ck <= 1'b0;
			@(posedge clk_i);
			ck <= 1'b1;
		end
	endtask

	// Blanking samples go out while sync is high; the clock stands still meanwhile.
	task automatic line_start();
		@(posedge clk_i);
		de <= 1'b0;
		hs <= 1'b1;
		d1 <= ycc ? 12'h080 : 12'h000;
		d2 <= ycc ? 12'h080 : 12'h000;
		repeat (2) @(posedge clk_i);
		hs <= 1'b0;
	endtask

	// A released bus shows the inverse of its last value so stale data never matches.
	task automatic idle();
		@(posedge clk_i);
		de <= 1'b0;
		d1 <= ~d1;
		d2 <= ~d2;
	endtask
endmodule

//--- pixel_decoder_pkg.sv
package pixel_decoder_pkg;

	// Register bus geometry and word offsets.
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;
	localparam logic [3:0]  REG_CONTROL     = 4'h0;
	localparam logic [3:0]  REG_STATUS      = 4'h4;
	localparam logic [3:0]  REG_PIXEL_COUNT = 4'h8;

	// Format selector codes.
	localparam logic [3:0]  FMT_RGB565      = 4'h2;
	localparam logic [3:0]  FMT_RGB555      = 4'h3;
	localparam logic [3:0]  FMT_YCC422      = 4'h4;
	localparam logic [3:0]  FMT_RGB24_TV    = 4'h5;
	localparam logic [3:0]  FMT_YCC24       = 4'h6;
	localparam logic [3:0]  FMT_YCC16       = 4'h7;
	localparam logic [3:0]  FMT_RGB24_GANG  = 4'h8;
	localparam logic [3:0]  FMT_RGB24_ODDEV = 4'h9;

	// Embedded timing-reference code bytes and status byte bit positions.
	localparam logic [7:0]  TRC_ONES        = 8'hFF;
	localparam logic [7:0]  TRC_ZERO        = 8'h00;
	localparam int          SB_FIELD        = 6;
	localparam int          SB_VBLANK       = 5;
	localparam int          SB_EAV          = 4;

	// Status register bit positions.
	localparam int          ST_FIELD        = 0;
	localparam int          ST_VBLANK       = 1;
	localparam int          ST_EAV          = 2;
	localparam int          ST_INVALID      = 3;
	localparam int          ST_OVERFLOW     = 4;

	localparam int          CTRL_W          = 7;
	localparam int          CNT_W           = 16;
	localparam int          PIX_W           = 26;
	localparam int          FIFO_DEPTH      = 32;

	typedef struct packed {
		logic [11:0] data;
		logic        hsync;
		logic        vsync;
		logic        data_enable;
		logic        pixel_clock;
		logic        pixel_clock_inverted;
	} port_in_s;

	typedef struct packed {
		logic       port_sel;
		logic       dual_edge;
		logic       mux_capture_polarity;
		logic [3:0] input_format_select;
	} control_s;

	localparam control_s CTRL_RESET = '{1'b0, 1'b0, 1'b1, 4'h2};

	typedef struct packed {
		logic        field;
		logic        vblank;
		logic [23:0] pixel;
	} pixel_word_s;

	typedef enum logic [1:0] {
		TRC_IDLE = 2'b00,
		TRC_FF   = 2'b01,
		TRC_Z1   = 2'b10,
		TRC_Z2   = 2'b11
	} trc_e;

endpackage

//--- pixel_fifo.sv
module pixel_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [CW-1:0]    count_q;
	logic             push;
	logic             pop;

	assign in_ready_o = (count_q != CW'(DEPTH));
	assign push       = in_valid_i && in_ready_o;
	// The output stage refills whenever it is empty or being drained.
	assign pop        = (count_q != '0) && (!out_valid_o || out_ready_i);

	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
			end
			if (pop)
			begin
				rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
			end
			count_q <= CW'(count_q + CW'(push) - CW'(pop));
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end
		else if (pop)
		begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem_q[rd_ptr_q];
		end
		else if (out_ready_i)
		begin
			out_valid_o <= 1'b0;
		end
	end

endmodule

//--- pixel_input_format_decoder.sv
// Overview of operation
// - Format 2 word a holds G4..2 and B7..3; word b holds ..3, G7..5.
// - Format 3 word a holds G5..3, B7..3; word b skips bit 11, ..3, G7..6.
// - Format 4 bytes on bits 7..0 repeat Cb, Y, Cr, Y; two Y share chroma. Here the first Y leaves with the previous Cr.
// - Format 4 accepts embedded sync codes starting in a Cb slot.
// - Sync code is FF, 00, 00, status byte; normal data then resumes.
// - Status bit 6 is the field flag, one for the second field.
// - Status bit 5 is vertical blanking flag.
// - Status bits 7 and 3..0 are ignored.
// - Both 12-bit ports may be ganged into one 24-bit input.
// - A setting picks which port's timing set drives the ganged input.
// - Ganged data is taken on one chosen edge or on both edges.
// - Ganged format codes are 5 to 9.
// - 16-bit YCrCb alternates Cb with Y0, then Cr with Y1.
// - First capture after hsync leading edge is word a of a pixel.
// - Polarity picks true-clock rising or inverted-clock falling edge.
//
// Our own choices: strobed register access and the register offsets.
module pixel_input_format_decoder (
	input  wire logic                              clk_i,
	input  wire logic                              srst_i,
	input  wire logic [pixel_decoder_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [pixel_decoder_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                              reg_write_i,
	input  wire logic                              reg_read_i,
	output logic      [pixel_decoder_pkg::DATA_W-1:0] reg_rdata_o,
	input  wire pixel_decoder_pkg::port_in_s       port1_i,
	input  wire pixel_decoder_pkg::port_in_s       port2_i,
	output logic                                   pixel_valid_o,
	input  wire logic                              pixel_ready_i,
	output pixel_decoder_pkg::pixel_word_s         pixel_o,
	output logic                                   field_o,
	output logic                                   vblank_o,
	output logic                                   fifo_room_o
);
	pixel_decoder_pkg::control_s    ctrl_q;
	pixel_decoder_pkg::port_in_s    p1_q;
	pixel_decoder_pkg::port_in_s    p2_q;
	pixel_decoder_pkg::port_in_s    sel;
	pixel_decoder_pkg::trc_e        trc_q;
	pixel_decoder_pkg::pixel_word_s push_word_q;
	logic [3:0]                     fmt;
	logic [11:0]                    mux_word;
	logic [23:0]                    gang_word;
	logic [7:0]                     byte_in;
	logic                           clk_prev_q;
	logic                           clkn_prev_q;
	logic                           hs_prev_q;
	logic                           cap;
	logic                           hs_lead;
	logic                           fmt_ok;
	logic                           phase_q;
	logic                           phase_d;
	logic [1:0]                     seq_q;
	logic [1:0]                     seq_d;
	logic                           cphase_q;
	logic                           cphase_d;
	logic                           trc_start;
	logic [11:0]                    word_a_q;
	logic [7:0]                     cb_q;
	logic [7:0]                     cr_q;
	logic                           field_q;
	logic                           vblank_q;
	logic                           eav_q;
	logic                           overflow_q;
	logic [pixel_decoder_pkg::CNT_W-1:0] pix_count_q;
	logic                           push_d;
	logic [23:0]                    pix_d;
	logic                           push_q;
	logic                           fifo_in_ready;

	assign fmt       = ctrl_q.input_format_select;
	assign fmt_ok    = (fmt >= pixel_decoder_pkg::FMT_RGB565)
	                && (fmt <= pixel_decoder_pkg::FMT_RGB24_ODDEV);
	// The selected port supplies timing, and the data too in multiplexed formats.
	assign sel       = ctrl_q.port_sel ? p2_q : p1_q;
	assign mux_word  = sel.data;
	assign gang_word = {p1_q.data, p2_q.data};
	assign byte_in   = mux_word[7:0];
	assign hs_lead   = sel.hsync && !hs_prev_q;

	// Pixel clocks are sampled levels; an edge shows as a change between samples.
	always_comb
	begin
		if (ctrl_q.dual_edge)
		begin
			cap = sel.pixel_clock != clk_prev_q;
		end
		else if (ctrl_q.mux_capture_polarity)
		begin
			cap = sel.pixel_clock && !clk_prev_q;
		end
		else
		begin
			cap = !sel.pixel_clock_inverted && clkn_prev_q;
		end
	end

	// A capture that coincides with the hsync leading edge is already word a.
	assign phase_d   = hs_lead ? 1'b0 : phase_q;
	assign seq_d     = hs_lead ? 2'h0 : seq_q;
	assign cphase_d  = hs_lead ? 1'b0 : cphase_q;
	assign trc_start = (trc_q == pixel_decoder_pkg::TRC_IDLE) && (seq_d == 2'h0)
	                && (byte_in == pixel_decoder_pkg::TRC_ONES);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			p1_q        <= '0;
			p2_q        <= '0;
			clk_prev_q  <= 1'b0;
			clkn_prev_q <= 1'b0;
			hs_prev_q   <= 1'b0;
		end
		else
		begin
			p1_q        <= port1_i;
			p2_q        <= port2_i;
			clk_prev_q  <= sel.pixel_clock;
			clkn_prev_q <= sel.pixel_clock_inverted;
			hs_prev_q   <= sel.hsync;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			phase_q  <= 1'b0;
			cphase_q <= 1'b0;
			word_a_q <= '0;
		end
		else
		begin
			phase_q  <= cap ? !phase_d : phase_d;
			cphase_q <= cap ? !cphase_d : cphase_d;
			if (cap && !phase_d)
			begin
				word_a_q <= mux_word;
			end
		end
	end

	// Embedded timing-reference tracking; a broken code drops back to idle.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			trc_q    <= pixel_decoder_pkg::TRC_IDLE;
			seq_q    <= 2'h0;
			field_q  <= 1'b0;
			vblank_q <= 1'b0;
			eav_q    <= 1'b0;
		end
		else if (cap && fmt == pixel_decoder_pkg::FMT_YCC422)
		begin
			seq_q <= 2'h0;
			case (trc_q)
				pixel_decoder_pkg::TRC_IDLE:
				begin
					if (trc_start)
					begin
						trc_q <= pixel_decoder_pkg::TRC_FF;
					end
					else
					begin
						seq_q <= 2'(seq_d + 2'h1);
					end
				end
				pixel_decoder_pkg::TRC_FF:
				begin
					trc_q <= (byte_in == pixel_decoder_pkg::TRC_ZERO)
					       ? pixel_decoder_pkg::TRC_Z1 : pixel_decoder_pkg::TRC_IDLE;
				end
				pixel_decoder_pkg::TRC_Z1:
				begin
					trc_q <= (byte_in == pixel_decoder_pkg::TRC_ZERO)
					       ? pixel_decoder_pkg::TRC_Z2 : pixel_decoder_pkg::TRC_IDLE;
				end
				pixel_decoder_pkg::TRC_Z2:
				begin
					// Only the F, V and H bits are decoded; the rest are don't-care.
					field_q  <= byte_in[pixel_decoder_pkg::SB_FIELD];
					vblank_q <= byte_in[pixel_decoder_pkg::SB_VBLANK];
					eav_q    <= byte_in[pixel_decoder_pkg::SB_EAV];
					trc_q    <= pixel_decoder_pkg::TRC_IDLE;
				end
				default:
				begin
					trc_q <= pixel_decoder_pkg::TRC_IDLE;
				end
			endcase
		end
		else if (hs_lead)
		begin
			seq_q <= 2'h0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			cb_q <= 8'h80;
			cr_q <= 8'h80;
		end
		else if (cap && fmt == pixel_decoder_pkg::FMT_YCC422
		         && trc_q == pixel_decoder_pkg::TRC_IDLE && !trc_start)
		begin
			if (seq_d == 2'h0)
			begin
				cb_q <= byte_in;
			end
			else if (seq_d == 2'h2)
			begin
				cr_q <= byte_in;
			end
		end
		else if (cap && fmt == pixel_decoder_pkg::FMT_YCC16)
		begin
			if (!cphase_d)
			begin
				cb_q <= gang_word[15:8];
			end
			else
			begin
				cr_q <= gang_word[15:8];
			end
		end
	end

	// YCrCb pixels leave as Y in 23..16, Cb in 15..8, Cr in 7..0.
	always_comb
	begin
		push_d = 1'b0;
		pix_d  = '0;
		if (cap && fmt_ok && sel.data_enable)
		begin
			case (fmt)
				pixel_decoder_pkg::FMT_RGB565:
				begin
					push_d = phase_d;
					pix_d  = {mux_word[11:7], 3'h0, mux_word[6:4], word_a_q[11:9], 2'h0,
					          word_a_q[8:4], 3'h0};
				end
				pixel_decoder_pkg::FMT_RGB555:
				begin
					push_d = phase_d;
					pix_d  = {mux_word[10:6], 3'h0, mux_word[5:4], word_a_q[11:9], 3'h0,
					          word_a_q[8:4], 3'h0};
				end
				pixel_decoder_pkg::FMT_YCC422:
				begin
					push_d = (trc_q == pixel_decoder_pkg::TRC_IDLE) && !trc_start && seq_d[0];
					pix_d  = {byte_in, cb_q, cr_q};
				end
				pixel_decoder_pkg::FMT_YCC24:
				begin
					push_d = 1'b1;
					pix_d  = {gang_word[23:16], gang_word[7:0], gang_word[15:8]};
				end
				pixel_decoder_pkg::FMT_YCC16:
				begin
					push_d = 1'b1;
					pix_d  = cphase_d ? {gang_word[23:16], cb_q, gang_word[15:8]}
					                  : {gang_word[23:16], gang_word[15:8], cr_q};
				end
				pixel_decoder_pkg::FMT_RGB24_TV,
				pixel_decoder_pkg::FMT_RGB24_GANG,
				pixel_decoder_pkg::FMT_RGB24_ODDEV:
				begin
					push_d = 1'b1;
					pix_d  = gang_word;
				end
				default:
				begin
					push_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			push_q      <= 1'b0;
			push_word_q <= '0;
		end
		else
		begin
			push_q      <= push_d;
			push_word_q <= '{field_q, vblank_q, pix_d};
		end
	end

	// The source cannot be stalled, so a full buffer drops pixels and flags it.
	pixel_fifo #(
		.WIDTH (pixel_decoder_pkg::PIX_W),
		.DEPTH (pixel_decoder_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.in_valid_i  (push_q),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_word_q),
		.out_valid_o (pixel_valid_o),
		.out_ready_i (pixel_ready_i),
		.out_data_o  (pixel_o)
	);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ctrl_q <= pixel_decoder_pkg::CTRL_RESET;
		end
		else if (reg_write_i && reg_addr_i == pixel_decoder_pkg::REG_CONTROL)
		begin
			ctrl_q <= reg_wdata_i[pixel_decoder_pkg::CTRL_W-1:0];
		end
	end

	// A new overflow in the clearing cycle survives the clear.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			overflow_q <= 1'b0;
		end
		else if (push_q && !fifo_in_ready)
		begin
			overflow_q <= 1'b1;
		end
		else if (reg_write_i && reg_addr_i == pixel_decoder_pkg::REG_STATUS
		         && reg_wdata_i[pixel_decoder_pkg::ST_OVERFLOW])
		begin
			overflow_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			pix_count_q <= '0;
			fifo_room_o <= 1'b0;
			field_o     <= 1'b0;
			vblank_o    <= 1'b0;
		end
		else
		begin
			if (push_q && fifo_in_ready)
			begin
				pix_count_q <= pixel_decoder_pkg::CNT_W'(pix_count_q + 1'b1);
			end
			fifo_room_o <= fifo_in_ready;
			field_o     <= field_q;
			vblank_o    <= vblank_q;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			reg_rdata_o <= '0;
		end
		else
		begin
			reg_rdata_o <= '0;
			if (reg_read_i)
			begin
				case (reg_addr_i)
					pixel_decoder_pkg::REG_CONTROL:
					begin
						reg_rdata_o[pixel_decoder_pkg::CTRL_W-1:0] <= ctrl_q;
					end
					pixel_decoder_pkg::REG_STATUS:
					begin
						reg_rdata_o[pixel_decoder_pkg::ST_FIELD]    <= field_q;
						reg_rdata_o[pixel_decoder_pkg::ST_VBLANK]   <= vblank_q;
						reg_rdata_o[pixel_decoder_pkg::ST_EAV]      <= eav_q;
						reg_rdata_o[pixel_decoder_pkg::ST_INVALID]  <= !fmt_ok;
						reg_rdata_o[pixel_decoder_pkg::ST_OVERFLOW] <= overflow_q;
					end
					pixel_decoder_pkg::REG_PIXEL_COUNT:
					begin
						reg_rdata_o[pixel_decoder_pkg::CNT_W-1:0] <= pix_count_q;
					end
					default:
					begin
						reg_rdata_o <= '0;
					end
				endcase
			end
		end
	end

	fmt2_red_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cap && sel.data_enable && phase_d && fmt == pixel_decoder_pkg::FMT_RGB565)
		|=> push_q && push_word_q.pixel[23:16] == {$past(mux_word[11:7]), 3'h0})
		else $error("format 2 red bits misplaced");

	fmt3_red_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cap && sel.data_enable && phase_d && fmt == pixel_decoder_pkg::FMT_RGB555)
		|=> push_q && push_word_q.pixel[23:19] == $past(mux_word[10:6]))
		else $error("format 3 red bits misplaced");

	ycc_sequence_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cap && fmt == pixel_decoder_pkg::FMT_YCC422 && !trc_start
		 && trc_q == pixel_decoder_pkg::TRC_IDLE)
		|=> seq_q == 2'($past(seq_d) + 2'h1))
		else $error("4:2:2 byte order lost");

	trc_field_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cap && fmt == pixel_decoder_pkg::FMT_YCC422 && trc_q == pixel_decoder_pkg::TRC_Z2)
		|=> field_q == $past(byte_in[6]) && trc_q == pixel_decoder_pkg::TRC_IDLE && seq_q == 2'h0)
		else $error("field flag not taken from status byte");

	trc_flags_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cap && fmt == pixel_decoder_pkg::FMT_YCC422 && trc_q == pixel_decoder_pkg::TRC_Z2)
		|=> vblank_q == $past(byte_in[5]) && eav_q == $past(byte_in[4]) ##1 vblank_o == vblank_q)
		else $error("blanking or marker flag wrong");

	hsync_phase_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(hs_lead && !cap) |=> !phase_q)
		else $error("hsync edge did not realign pixel words");

	invalid_fmt_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!fmt_ok |=> !push_q)
		else $error("pixel produced under unsupported format");

	edge_pick_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cap && !ctrl_q.dual_edge) |-> (ctrl_q.mux_capture_polarity
		 ? $rose(sel.pixel_clock) : $fell(sel.pixel_clock_inverted)))
		else $error("capture on wrong clock edge");

	overflow_sticky_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(push_q && !fifo_in_ready) |=> overflow_q)
		else $error("dropped pixel not flagged");

endmodule

//--- tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [3:0]  fmt;
		logic [23:0] w0;
		logic [23:0] w1;
		int          n;
		logic [23:0] e0;
		logic [23:0] e1;
	} row_s;

	logic                                 clk_i       = 1'b0;
	logic                                 srst_i      = 1'b1;
	logic [pixel_decoder_pkg::ADDR_W-1:0] reg_addr_i  = 4'h0;
	logic [pixel_decoder_pkg::DATA_W-1:0] reg_wdata_i = 32'h0;
	logic                                 reg_write_i = 1'b0;
	logic                                 reg_read_i  = 1'b0;
	logic [pixel_decoder_pkg::DATA_W-1:0] reg_rdata_o;
	pixel_decoder_pkg::port_in_s          port1_i;
	pixel_decoder_pkg::port_in_s          port2_i;
	logic                                 pixel_valid_o;
	logic                                 pixel_ready_i = 1'b1;
	pixel_decoder_pkg::pixel_word_s       pixel_o;
	logic                                 field_o;
	logic                                 vblank_o;
	logic                                 fifo_room_o;
	logic [25:0]                          got[$];
	logic [31:0]                          rd;
	logic [7:0]                           seq[12] = '{8'hFF, 8'h00, 8'h00, 8'hCF, 8'h40, 8'h50,
		8'h60, 8'h70, 8'h44, 8'h55, 8'h66, 8'h77};
	logic [7:0]                           code[4] = '{8'hFF, 8'h00, 8'h00, 8'h30};
	logic [31:0]                          edge_ctl[2] = '{32'h38, 32'h08};
	int                                   fails    = 0;
	int                                   compares = 0;
	row_s                                 rows[6]  = '{
		'{4'h2, 24'hA5F5A0, 24'h6C393C, 1, 24'h689428, 24'h0},
		'{4'h3, 24'hA5F5A0, 24'hED312C, 1, 24'hD86828, 24'h0},
		'{4'h5, 24'h123456, 24'hFEDCBA, 2, 24'h123456, 24'hFEDCBA},
		'{4'h6, 24'hABCDEF, 24'h102030, 2, 24'hABEFCD, 24'h103020},
		'{4'h8, 24'h0F1E2D, 24'h3C4B5A, 2, 24'h0F1E2D, 24'h3C4B5A},
		'{4'h9, 24'h00FF00, 24'hA5A5A5, 2, 24'h00FF00, 24'hA5A5A5}};

	always #20 clk_i = ~clk_i;

	always @(posedge clk_i)
		if (pixel_valid_o === 1'b1 && pixel_ready_i)
			got.push_back(pixel_o);

	pixel_input_format_decoder DUT (
		.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
		.port1_i(port1_i), .port2_i(port2_i), .pixel_valid_o(pixel_valid_o),
		.pixel_ready_i(pixel_ready_i), .pixel_o(pixel_o), .field_o(field_o),
		.vblank_o(vblank_o), .fifo_room_o(fifo_room_o));

	gfx_source src (.clk_i(clk_i), .port1_o(port1_i), .port2_o(port2_i));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		#1 rd = reg_rdata_o;
	endtask

	task automatic start(input logic [31:0] ctl);
		reg_wr(pixel_decoder_pkg::REG_CONTROL, ctl);
		got.delete();
		src.line_start();
	endtask

	task automatic send(input logic [23:0] w);
		src.word(w[23:12], w[11:0]);
	endtask

	// The extra cycles catch stray pixels that arrive after the expected ones.
	task automatic drain(input int n);
		src.idle();
		for (int k = 0; k < 100 && got.size() < n; k++)
			@(posedge clk_i);
		repeat (8) @(posedge clk_i);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		fails++;
		$display("BAD %0t watchdog expired", $time);
		finish_test();
	end

	initial
	begin
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		#1 check({pixel_valid_o, field_o, vblank_o}, 0, "outputs after reset");
		reg_rd(pixel_decoder_pkg::REG_CONTROL);
		check(rd, 32'h12, "control reset");
		reg_wr(4'hC, 32'hFFFFFFFF);
		reg_rd(4'hC);
		check(rd, 32'h0, "unmapped read");
		reg_rd(pixel_decoder_pkg::REG_CONTROL);
		check(rd, 32'h12, "unmapped write leaked");
		reg_rd(pixel_decoder_pkg::REG_STATUS);
		check(rd, 32'h0, "status reset");
		reg_rd(pixel_decoder_pkg::REG_PIXEL_COUNT);
		check(rd, 32'h0, "count reset");
		$display("test reset done");

		foreach (rows[i])
		begin
			start(32'h10 | rows[i].fmt);
			send(rows[i].w0);
			send(rows[i].w1);
			drain(rows[i].n);
			check(got.size(), rows[i].n, "row count");
			for (int j = 0; j < rows[i].n; j++)
				check(got[j][23:0], j ? rows[i].e1 : rows[i].e0, "row pixel");
			$display("test format %0d done", rows[i].fmt);
		end
		reg_rd(pixel_decoder_pkg::REG_PIXEL_COUNT);
		check(rd, 32'hA, "pixel count");

		for (int c = 0; c < 16; c++)
			if (c < 2 || c > 9)
			begin
				start(32'h10 | c);
				send(24'h123456);
				send(24'h789ABC);
				drain(0);
				check(got.size(), 0, "unsupported code");
				reg_rd(pixel_decoder_pkg::REG_STATUS);
				check(rd[3], 1'b1, "invalid flag");
			end
		$display("test unsupported done");

		// A stray first word before sync must not pair with the next line.
		start(32'h12);
		send(24'hFFF000);
		src.line_start();
		send(24'hA5F5A0);
		send(24'h6C393C);
		drain(1);
		check(got.size(), 1, "resync count");
		check(got[0][23:0], 24'h689428, "resync pixel");
		$display("test resync done");

		src.clk_mask <= 2'b10;
		start(32'h52);
		send(24'h000A5F);
		send(24'h0006C3);
		drain(1);
		check(got.size(), 1, "port2 count");
		check(got[0][23:0], 24'h689428, "port2 pixel");
		start(32'h12);
		send(24'hA5F000);
		send(24'h6C3000);
		drain(0);
		check(got.size(), 0, "idle port timing");
		src.clk_mask <= 2'b11;
		$display("test port select done");

		foreach (edge_ctl[i])
		begin
			src.dual = edge_ctl[i][5];
			start(edge_ctl[i]);
			send(24'h13579B);
			send(24'h2468AC);
			drain(2);
			check(got.size(), 2, "edge count");
			check(got[0][23:0], 24'h13579B, "edge first pixel");
			check(got[1][23:0], 24'h2468AC, "edge pixel");
		end
		src.dual = 1'b0;
		$display("test edges done");

		src.ycc = 1'b1;
		start(32'h14);
		foreach (seq[i])
			send({4'h5, seq[i], 12'hC3C});
		drain(4);
		check({field_o, vblank_o}, 2'b10, "flags after code");
		check(got.size(), 4, "ycc count");
		check(got[0][23:8], 16'h5040, "ycc first");
		check(got[1], {2'b10, 24'h704060}, "ycc second");
		check(got[2][23:0], 24'h554460, "ycc third");
		check(got[3][23:0], 24'h774466, "ycc fourth");
		reg_rd(pixel_decoder_pkg::REG_STATUS);
		check(rd[2:0], 3'b001, "status first code");
		foreach (code[i])
			send({4'h5, code[i], 12'hC3C});
		drain(4);
		check({field_o, vblank_o}, 2'b01, "flags second code");
		check(got.size(), 4, "code gave pixels");
		reg_rd(pixel_decoder_pkg::REG_STATUS);
		check(rd[2:0], 3'b110, "status second code");
		src.ycc = 1'b0;
		$display("test embedded sync done");

		start(32'h17);
		for (int i = 0; i < 4; i++)
			send({8'h11 + 8'(8'h22 * i), 8'h22 + 8'(8'h22 * i), 8'h5A});
		drain(4);
		check(got.size(), 4, "ycc16 count");
		check(got[0][23:8], 16'h1122, "ycc16 first");
		check(got[1][23:0], 24'h332244, "ycc16 second");
		check(got[2][23:0], 24'h556644, "ycc16 third");
		check(got[3][23:0], 24'h776688, "ycc16 fourth");
		$display("test ycc16 done");

		pixel_ready_i <= 1'b0;
		start(32'h18);
		for (int i = 0; i < 40; i++)
			send({12'(i), 12'(i)});
		drain(0);
		check(fifo_room_o, 1'b0, "fifo full");
		reg_rd(pixel_decoder_pkg::REG_STATUS);
		check(rd[4], 1'b1, "overflow set");
		pixel_ready_i <= 1'b1;
		drain(33);
		// The buffer holds 32 entries and its output register one more.
		check(got.size(), 33, "fifo depth");
		foreach (got[i])
			check(got[i][23:0], {12'(i), 12'(i)}, "fifo order");
		reg_wr(pixel_decoder_pkg::REG_STATUS, 32'h10);
		reg_rd(pixel_decoder_pkg::REG_STATUS);
		check(rd[4], 1'b0, "overflow clear");
		check(fifo_room_o, 1'b1, "fifo room back");
		$display("test fifo done");
		finish_test();
	end
endmodule
